// ===== rtl/hsou_defs.vh
// constants for the hybrid stack operand unit
`ifndef HSOU_DEFS_VH
`define HSOU_DEFS_VH
// opcode operand field layout: pop bit over a 3-bit stack index
`define HSOU_FLD_W      4
`define HSOU_FLD_POP    3
`define HSOU_IDX_W      3
`define HSOU_NSTK       8
// default build values
`define HSOU_DATA_W     32
`define HSOU_OPC_W      16
`define HSOU_DEPTH_LOG2 5
`define HSOU_THR_W      3
`define HSOU_PC_W       16
`define HSOU_ADDR_W     16
`define HSOU_REG_AW     4
`define HSOU_OFS_W      4
// the stack that receives interrupt return addresses
`define HSOU_IRQ_STK    3'h0
// operation classes from the decoder
`define HSOU_OP_NONE    4'h0
`define HSOU_OP_ALU1    4'h1
`define HSOU_OP_ALU2    4'h2
`define HSOU_OP_BR1     4'h3
`define HSOU_OP_BR2     4'h4
`define HSOU_OP_MRD     4'h5
`define HSOU_OP_MWR     4'h6
`define HSOU_OP_RRD     4'h7
`define HSOU_OP_RWR     4'h8
`define HSOU_OP_CALL    4'h9
// alu functions
`define HSOU_AF_ADD     3'h0
`define HSOU_AF_SUB     3'h1
`define HSOU_AF_MUL     3'h2
`define HSOU_AF_NOT     3'h3
`define HSOU_AF_SHR     3'h4
`define HSOU_AF_CPY     3'h5
// branch conditions
`define HSOU_BC_EQ      2'h0
`define HSOU_BC_NE      2'h1
`define HSOU_BC_GT      2'h2
`define HSOU_BC_LT      2'h3
// memory width selector
`define HSOU_MW_16      1'b0
`define HSOU_MW_32      1'b1
`endif

// ===== rtl/hsou_unit.v
// hybrid stack operand unit: per-thread lifo stacks used as operands
//
// The placing of the registers and strobed register access were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "hsou_defs.vh"
module hsou_unit #(
	parameter DATA_W     = `HSOU_DATA_W,
	parameter OPC_W      = `HSOU_OPC_W,
	parameter DEPTH_LOG2 = `HSOU_DEPTH_LOG2,
	parameter THR_W      = `HSOU_THR_W,
	parameter PC_W       = `HSOU_PC_W,
	parameter ADDR_W     = `HSOU_ADDR_W,
	parameter REG_AW     = `HSOU_REG_AW,
	parameter PUSH_PROT  = 1,
	parameter POP_PROT   = 1
)(
	// clock and reset
	input  wire                  core_clk_i,
	input  wire                  rst_i,
	// decoded instruction
	input  wire                  op_vld_i,
	input  wire [3:0]            op_cls_i,
	input  wire [2:0]            alu_fn_i,
	input  wire                  alu_hi_i,
	input  wire                  alu_sgn_i,
	input  wire [1:0]            br_cond_i,
	input  wire                  br_imm_sel_i,
	input  wire                  mem_wide_i,
	input  wire [OPC_W-1:0]      opcode_i,
	input  wire [DATA_W-1:0]     imm_i,
	input  wire [THR_W-1:0]      thr_i,
	input  wire [PC_W-1:0]       pc_i,
	input  wire                  irq_take_i,
	// memory and register set return data
	input  wire [DATA_W-1:0]     mem_rdata_i,
	input  wire [DATA_W-1:0]     reg_rdata_i,
	// pc results
	output reg                   pc_load_o,
	output reg  [PC_W-1:0]       pc_nxt_o,
	// main memory request
	output reg                   mem_rd_o,
	output reg                   mem_wr_o,
	output reg                   mem_wide_o,
	output reg  [ADDR_W-1:0]     mem_addr_o,
	output reg  [DATA_W-1:0]     mem_wdata_o,
	// register set request
	output reg                   reg_rd_o,
	output reg                   reg_wr_o,
	output reg  [REG_AW-1:0]     reg_addr_o,
	output reg  [DATA_W-1:0]     reg_wdata_o,
	// stack error report
	output reg                   err_push_o,
	output reg                   err_pop_o,
	output reg  [THR_W-1:0]      err_thr_o,
	output reg  [`HSOU_NSTK-1:0] err_stk_o
);
	localparam NT   = 1 << THR_W;
	localparam NS   = `HSOU_NSTK;
	localparam SLOT = NT * NS;
	localparam DEP  = 1 << DEPTH_LOG2;
	localparam LVW  = DEPTH_LOG2 + 1;
	localparam SW   = THR_W + 3;

	// ****************************************
	// operand field decode
	// ****************************************
	// low byte of the opcode holds B then A fields
	wire [2:0] idx_b = opcode_i[2:0];
	wire       pop_b = opcode_i[`HSOU_FLD_POP];
	wire [2:0] idx_a = opcode_i[6:4];
	wire       pop_a = opcode_i[4+`HSOU_FLD_POP];

	// ****************************************
	// stack storage
	// ****************************************
	reg [DATA_W-1:0]  mem_r [0:SLOT*DEP-1];
	reg [LVW-1:0]     lvl_r [0:SLOT-1];
	reg [DATA_W-1:0]  top_r [0:SLOT-1];   // write-through top copy

	wire [SW-1:0] slot_a = {thr_i, idx_a};
	wire [SW-1:0] slot_b = {thr_i, idx_b};
	wire [SW-1:0] slot_0 = {thr_i, `HSOU_IRQ_STK};

	// only the top entry of a stack is ever visible
	wire [DATA_W-1:0] opa = top_r[slot_a];
	wire [DATA_W-1:0] opb = top_r[slot_b];
	wire [LVW-1:0]    lva = lvl_r[slot_a];
	wire [LVW-1:0]    lvb = lvl_r[slot_b];

	// pc zero-extended to the data width; filling the low bits keeps
	// working when the pc is built as wide as the data path
	reg [DATA_W-1:0] pc_ext;
	always @*
	begin
		pc_ext = {DATA_W{1'b0}};
		pc_ext[PC_W-1:0] = pc_i;
	end

	// ****************************************
	// operand roles per class
	// ****************************************
	reg        rd_a;
	reg        rd_b;
	reg        wr_a;
	reg [DATA_W-1:0] wval;
	reg [2*DATA_W-1:0] wide;
	reg [DATA_W:0]  ea;
	reg [DATA_W:0]  eb;
	reg        take;
	reg [PC_W-1:0] step;
	always @*
	begin
		rd_a = 1'b0;
		rd_b = 1'b0;
		wr_a = 1'b0;
		wval = {DATA_W{1'b0}};
		take = 1'b0;
		step = {PC_W{1'b0}};
		// sign or zero extend for the upper half and for the right shift
		ea = {alu_sgn_i & opa[DATA_W-1], opa};
		eb = {alu_sgn_i & opb[DATA_W-1], opb};
		wide = {2*DATA_W{1'b0}};
		case (alu_fn_i)
			`HSOU_AF_ADD: wide = {{(DATA_W-1){ea[DATA_W]}}, ea}
				+ {{(DATA_W-1){eb[DATA_W]}}, eb};
			`HSOU_AF_SUB: wide = {{(DATA_W-1){ea[DATA_W]}}, ea}
				- {{(DATA_W-1){eb[DATA_W]}}, eb};
			`HSOU_AF_MUL: wide = $signed({{(DATA_W-1){ea[DATA_W]}}, ea})
				* $signed({{(DATA_W-1){eb[DATA_W]}}, eb});
			`HSOU_AF_NOT: wide = {{DATA_W{1'b0}}, ~opb};
			// one step right: the extension bit of eb fills the top
			`HSOU_AF_SHR: wide = {{DATA_W{1'b0}},
				eb[DATA_W:1]};
			`HSOU_AF_CPY: wide = {{DATA_W{1'b0}}, opb};
			default:      wide = {2*DATA_W{1'b0}};
		endcase
		case (op_cls_i)
			`HSOU_OP_ALU1:
			begin
				rd_b = 1'b1;
				wr_a = 1'b1;
				wval = wide[DATA_W-1:0];
			end
			`HSOU_OP_ALU2:
			begin
				rd_a = 1'b1;
				rd_b = 1'b1;
				wr_a = 1'b1;
				wval = alu_hi_i ? wide[2*DATA_W-1:DATA_W]
					: wide[DATA_W-1:0];
			end
			`HSOU_OP_BR1:
			begin
				rd_a = 1'b1;
				rd_b = ~br_imm_sel_i;
				case (br_cond_i)
					`HSOU_BC_EQ: take = (opa == {DATA_W{1'b0}});
					`HSOU_BC_NE: take = (opa != {DATA_W{1'b0}});
					`HSOU_BC_GT: take = ~opa[DATA_W-1] & (|opa);
					default:     take = opa[DATA_W-1];
				endcase
				step = br_imm_sel_i ? imm_i[PC_W-1:0] : opb[PC_W-1:0];
			end
			`HSOU_OP_BR2:
			begin
				rd_a = 1'b1;
				rd_b = 1'b1;
				case (br_cond_i)
					`HSOU_BC_EQ: take = (opa == opb);
					`HSOU_BC_NE: take = (opa != opb);
					`HSOU_BC_GT: take = $signed(opa) > $signed(opb);
					default:     take = $signed(opa) < $signed(opb);
				endcase
				step = imm_i[PC_W-1:0];
			end
			`HSOU_OP_MRD:
			begin
				rd_b = 1'b1;
				wr_a = 1'b1;
				wval = mem_rdata_i;
			end
			`HSOU_OP_MWR:
			begin
				rd_a = 1'b1;
				rd_b = 1'b1;
			end
			`HSOU_OP_RRD:
			begin
				wr_a = 1'b1;
				wval = reg_rdata_i;
			end
			`HSOU_OP_RWR:
			begin
				rd_a = 1'b1;
			end
			`HSOU_OP_CALL:
			begin
				rd_b = 1'b1;
				wr_a = 1'b1;
				wval = pc_ext;
			end
			default:
			begin
				rd_a = 1'b0;
			end
		endcase
	end

	// ****************************************
	// stack pointer actions
	// ****************************************
	// a stack named twice gets its pop bits ORed, so at most one pop
	wire act    = op_vld_i & ~irq_take_i;
	wire same   = (idx_a == idx_b) & rd_b;
	wire popa_e = act & ((rd_a | wr_a) & pop_a | same & pop_b);
	wire pusha  = act & wr_a;
	wire popb_e = act & rd_b & pop_b & ~same;
	// an interrupt takes the whole cycle: the decoded instruction is
	// dropped and the unincremented pc goes to the return stack
	wire irq    = op_vld_i & irq_take_i;

	// levels run 0..depth with the extra top bit meaning full; the
	// pointer is the level without that bit, so the first push lands
	// at entry 1 and the last one of a full stack at entry 0
	// a pop ahead of a push on a full stack is legal: the pop frees
	// the slot that the push then takes
	// per-slot next state: one write path, one pop-only path
	wire [SW-1:0]     ws   = irq ? slot_0 : slot_a;
	wire              wpsh = irq | pusha;
	wire              wpop = ~irq & popa_e;
	wire [LVW-1:0]    wlv  = lvl_r[ws];
	wire [DATA_W-1:0] wdat = irq ? pc_ext : wval;
	wire              w_emp  = (wlv == {LVW{1'b0}});
	wire              w_full = wlv[LVW-1];
	wire              w_uerr = wpop & w_emp;
	wire              w_oerr = wpsh & ~wpop & w_full;            // pop first
	// empty pop and push: pop error only, protected result is one push
	wire [LVW-1:0]    w_dec = (w_uerr & (POP_PROT != 0)) ? wlv
		: wlv - {{(LVW-1){1'b0}}, wpop};
	wire              w_blk = w_oerr & (PUSH_PROT != 0);
	wire [LVW-1:0]    w_nlv = (wpsh & ~w_blk) ? w_dec + {{(LVW-1){1'b0}}, 1'b1}
		: w_dec;
	wire              b_uerr = popb_e & (lvb == {LVW{1'b0}});
	wire [LVW-1:0]    b_nlv  = (b_uerr & (POP_PROT != 0)) ? lvb
		: lvb - {{(LVW-1){1'b0}}, 1'b1};
	wire [DEPTH_LOG2-1:0] wptr = w_nlv[DEPTH_LOG2-1:0];
	wire [DEPTH_LOG2-1:0] bptr = b_nlv[DEPTH_LOG2-1:0];

	// ****************************************
	// stack update
	// ****************************************
	// storage arrays carry no reset; levels start empty
	integer k;
	always @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			for (k = 0; k < SLOT; k = k + 1)
				lvl_r[k] <= {LVW{1'b0}};
		end
		else
		begin
			if (wpsh | wpop)
				lvl_r[ws] <= w_nlv;
			if (popb_e)
				lvl_r[slot_b] <= b_nlv;
		end
	end

	// the top copy lets the very next instruction see a value pushed
	// in this cycle, which a registered memory read port could not
	// write-through: new top is the pushed value or the entry below
	always @(posedge core_clk_i)
	begin
		if (wpsh & ~w_blk)
		begin
			mem_r[{ws, wptr}] <= wdat;
			top_r[ws] <= wdat;
		end
		else if (wpop)
			top_r[ws] <= mem_r[{ws, wptr}];
		if (popb_e)
			top_r[slot_b] <= mem_r[{slot_b, bptr}];
	end

	// ****************************************
	// registered outputs
	// ****************************************
	// pc, memory and register set requests
	always @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			pc_load_o   <= 1'b0;
			pc_nxt_o    <= {PC_W{1'b0}};
			mem_rd_o    <= 1'b0;
			mem_wr_o    <= 1'b0;
			mem_wide_o  <= 1'b0;
			mem_addr_o  <= {ADDR_W{1'b0}};
			mem_wdata_o <= {DATA_W{1'b0}};
			reg_rd_o    <= 1'b0;
			reg_wr_o    <= 1'b0;
			reg_addr_o  <= {REG_AW{1'b0}};
			reg_wdata_o <= {DATA_W{1'b0}};
		end
		else
		begin
			pc_load_o <= act & (((op_cls_i == `HSOU_OP_BR1)
				| (op_cls_i == `HSOU_OP_BR2)) & take
				| (op_cls_i == `HSOU_OP_CALL));
			// not taken leaves the pc alone: no load
			pc_nxt_o <= (op_cls_i == `HSOU_OP_CALL) ? opb[PC_W-1:0]
				: pc_i + step;
			mem_rd_o <= act & (op_cls_i == `HSOU_OP_MRD);
			mem_wr_o <= act & (op_cls_i == `HSOU_OP_MWR);
			// any alignment is passed on; the memory splits as needed
			mem_wide_o <= mem_wide_i;
			mem_addr_o <= opb[ADDR_W-1:0]
				+ {{(ADDR_W-`HSOU_OFS_W){1'b0}},
				imm_i[`HSOU_OFS_W-1:0]};
			mem_wdata_o <= (mem_wide_i == `HSOU_MW_32) ? opa
				: {{(DATA_W-16){1'b0}}, opa[15:0]};
			reg_rd_o <= act & (op_cls_i == `HSOU_OP_RRD);
			reg_wr_o <= act & (op_cls_i == `HSOU_OP_RWR);
			reg_addr_o <= imm_i[REG_AW-1:0];
			reg_wdata_o <= opa;
		end
	end

	// ****************************************
	// stack error report
	// ****************************************
	// reported whatever protection is built in, so software still
	// learns of a push that the overflow guard quietly dropped
	always @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			err_push_o <= 1'b0;
			err_pop_o  <= 1'b0;
			err_thr_o  <= {THR_W{1'b0}};
			err_stk_o  <= {NS{1'b0}};
		end
		else
		begin
			err_push_o <= w_oerr;
			err_pop_o  <= w_uerr | b_uerr;
			err_thr_o  <= thr_i;
			err_stk_o  <= ((w_oerr | w_uerr) ? (8'h01 << ws[2:0]) : 8'h00)
				| (b_uerr ? (8'h01 << idx_b) : 8'h00);
		end
	end
endmodule
`default_nettype wire

// ===== tb/hsou_regset_model.sv
// register set model on the far side of the operand unit
`timescale 1ns/1ps
`default_nettype none
module hsou_regset_model (
	// clock and write request
	input  wire logic        clk_i,
	input  wire logic        wr_i,
	input  wire logic [3:0]  addr_i,
	input  wire logic [31:0] wdata_i,
	// read select and data in the same cycle
	input  wire logic [3:0]  sel_i,
	output logic      [31:0] rdata_o
);
	logic [31:0] mem_r [16];
	// a write lands on the edge after the pulse, so reads wait one cycle
	always @(posedge clk_i)
		if (wr_i)
			mem_r[addr_i] <= wdata_i;
	assign rdata_o = mem_r[sel_i];
endmodule
`default_nettype wire

// ===== tb/hsou_unit_monitor.sv
// concurrent checks on the operand unit ports
`timescale 1ns/1ps
`default_nettype none
`include "hsou_defs.vh"
module hsou_chk #(
	parameter PC_W   = 16,
	parameter THR_W  = 3,
	parameter REG_AW = 4
)(
	// clock, reset and request
	input wire logic              core_clk_i,
	input wire logic              rst_i,
	input wire logic              op_vld_i,
	input wire logic [3:0]        op_cls_i,
	input wire logic              irq_take_i,
	input wire logic              mem_wide_i,
	input wire logic [31:0]       imm_i,
	input wire logic [THR_W-1:0]  thr_i,
	input wire logic [PC_W-1:0]   pc_i,
	// answers
	input wire logic              pc_load_o,
	input wire logic [PC_W-1:0]   pc_nxt_o,
	input wire logic              mem_rd_o,
	input wire logic              mem_wr_o,
	input wire logic              mem_wide_o,
	input wire logic              reg_rd_o,
	input wire logic              reg_wr_o,
	input wire logic [REG_AW-1:0] reg_addr_o,
	input wire logic              err_push_o,
	input wire logic              err_pop_o,
	input wire logic [THR_W-1:0]  err_thr_o,
	input wire logic [7:0]        err_stk_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (rst_i);
	// an interrupt cycle discards the decoded instruction
	wire go = op_vld_i & ~irq_take_i;
	a_memrd_pulse: assert property (go && op_cls_i == `HSOU_OP_MRD
		|=> mem_rd_o && !mem_wr_o) else $error("memory read missing");
	a_memwr_width: assert property (go && op_cls_i == `HSOU_OP_MWR
		|=> mem_wr_o && mem_wide_o == $past(mem_wide_i))
		else $error("memory write wrong");
	a_regrd_addr: assert property (go && op_cls_i == `HSOU_OP_RRD
		|=> reg_rd_o && reg_addr_o == $past(imm_i[REG_AW-1:0]))
		else $error("register read wrong");
	a_regwr_pulse: assert property (go && op_cls_i == `HSOU_OP_RWR
		|=> reg_wr_o && !reg_rd_o) else $error("register write missing");
	a_call_jump: assert property (go && op_cls_i == `HSOU_OP_CALL
		|=> pc_load_o) else $error("call did not jump");
	a_br2_target: assert property (go && op_cls_i == `HSOU_OP_BR2
		##1 pc_load_o |-> pc_nxt_o == $past(pc_i) + $past(imm_i[PC_W-1:0]))
		else $error("branch target wrong");
	a_irq_quiet: assert property (op_vld_i && irq_take_i
		|=> !(mem_rd_o || mem_wr_o || reg_wr_o))
		else $error("instruction ran under interrupt");
	a_idle_quiet: assert property (!op_vld_i
		|=> !(mem_rd_o || mem_wr_o || reg_rd_o || reg_wr_o || pc_load_o))
		else $error("request without instruction");
	a_err_owner: assert property (err_push_o || err_pop_o
		|-> err_stk_o != 8'h00 && err_thr_o == $past(thr_i))
		else $error("error report wrong");
endmodule
bind hsou_unit hsou_chk #(.PC_W(PC_W), .THR_W(THR_W), .REG_AW(REG_AW))
	u_chk (.core_clk_i(core_clk_i), .rst_i(rst_i), .op_vld_i(op_vld_i),
	.op_cls_i(op_cls_i), .irq_take_i(irq_take_i), .mem_wide_i(mem_wide_i),
	.imm_i(imm_i), .thr_i(thr_i), .pc_i(pc_i), .pc_load_o(pc_load_o),
	.pc_nxt_o(pc_nxt_o), .mem_rd_o(mem_rd_o), .mem_wr_o(mem_wr_o),
	.mem_wide_o(mem_wide_o), .reg_rd_o(reg_rd_o), .reg_wr_o(reg_wr_o),
	.reg_addr_o(reg_addr_o), .err_push_o(err_push_o),
	.err_pop_o(err_pop_o), .err_thr_o(err_thr_o), .err_stk_o(err_stk_o));
`default_nettype wire

// ===== tb/hsou_unit_tb.sv
// self-checking testbench for the hybrid stack operand unit
`timescale 1ns/1ps
`default_nettype none
`include "hsou_defs.vh"
module hsou_unit_tb;
	logic clk = 0, rst = 1, vld = 0, hi = 0, irq = 0, wide = 1, bsel = 0;
	logic        sgn = 0;
	logic [4:0]  fx = 0;   // flags of the next op: sgn irq bsel hi narrow
	logic [3:0]  cls = 0;
	logic [2:0]  fn = 0, thr = 0, et;
	logic [1:0]  bc = 0;
	logic [15:0] opc = 0, pc = 0, pn, ma;
	logic [31:0] imm = 0, mrd = 0, rrd, wd, rwd;
	logic        pl, mr, mw, mwo, rr, rw, eu, eo;
	logic [3:0]  ra;
	logic [7:0]  es;
	int          err_count = 0, n_checks = 0;
	// depth 4 keeps the full-stack case short
	hsou_unit #(.DEPTH_LOG2(2)) uut (.core_clk_i(clk), .rst_i(rst),
		.op_vld_i(vld), .op_cls_i(cls), .alu_fn_i(fn), .alu_hi_i(hi),
		.alu_sgn_i(sgn), .br_cond_i(bc), .br_imm_sel_i(bsel),
		.mem_wide_i(wide), .opcode_i(opc), .imm_i(imm), .thr_i(thr),
		.pc_i(pc), .irq_take_i(irq), .mem_rdata_i(mrd), .reg_rdata_i(rrd),
		.pc_load_o(pl), .pc_nxt_o(pn), .mem_rd_o(mr), .mem_wr_o(mw),
		.mem_wide_o(mwo), .mem_addr_o(ma), .mem_wdata_o(wd), .reg_rd_o(rr),
		.reg_wr_o(rw), .reg_addr_o(ra), .reg_wdata_o(rwd),
		.err_push_o(eu), .err_pop_o(eo), .err_thr_o(et), .err_stk_o(es));
	hsou_regset_model u_regs (.clk_i(clk), .wr_i(rw), .addr_i(ra),
		.wdata_i(rwd), .sel_i(imm[3:0]), .rdata_o(rrd));
	always #12.5 clk = ~clk;
	task chk(input logic [63:0] g, input logic [63:0] e);
		n_checks++;
		if (g !== e)
		begin
			err_count++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	// one instruction per edge; set fx beforehand for the odd flags,
	// so that no input is driven twice in one time step
	task op(input [3:0] c, input [2:0] f, input [7:0] ab, input [31:0] i,
		input [31:0] m);
		@(posedge clk);
		vld <= 1;
		cls <= c;
		fn <= f;
		opc <= {8'h00, ab};
		imm <= i;
		mrd <= m;
		wide <= ~fx[0];
		hi <= fx[1];
		bsel <= fx[2];
		irq <= fx[3];
		sgn <= fx[4];
		fx = 5'h00;
	endtask
	task w;
		@(posedge clk);
		vld <= 0;
		#1;
	endtask
	// push a literal through the memory read path
	task ld(input [2:0] s, input [31:0] v);
		op(`HSOU_OP_MRD, 0, {1'b0, s, 4'h7}, 0, v);
	endtask
	// top of a stack appears as memory write data
	task pk(input p, input [2:0] s, input [31:0] e);
		op(`HSOU_OP_MWR, 0, {p, s, 4'h7}, 0, 0);
		w;
		chk(wd, e);
		chk(eo, 0);
	endtask
	task er(input [2:0] s);
		op(`HSOU_OP_MWR, 0, {1'b1, s, 4'h7}, 0, 0);
		w;
		chk({eo, es}, {1'b1, 8'h01 << s});
	endtask
	// ****************************************
	// scenarios
	// ****************************************
	task t_modes;
		ld(1, 5);
		ld(1, 7);
		ld(2, 3);
		pk(0, 1, 7);
		pk(1, 1, 7);
		pk(0, 1, 5);
		op(`HSOU_OP_ALU2, `HSOU_AF_ADD, 8'h92, 0, 0);
		pk(1, 1, 8);
		pk(0, 2, 3);
		er(1);
		ld(3, 6);
		op(`HSOU_OP_ALU2, `HSOU_AF_MUL, 8'hbb, 0, 0);
		pk(1, 3, 32'h24);
		er(3);
	endtask
	task t_alu;
		ld(4, 32'h0f);
		op(`HSOU_OP_ALU1, `HSOU_AF_NOT, 8'h54, 0, 0);
		pk(0, 5, 32'hfffffff0);
		pk(0, 4, 32'h0f);
		ld(6, 32'hffffffff);
		fx = 5'h02;
		op(`HSOU_OP_ALU2, `HSOU_AF_ADD, 8'he2, 0, 0);
		pk(0, 6, 1);
		// signed right shift of the top of stack 5, then an unsigned right shift of that result
		fx = 5'h10;
		op(`HSOU_OP_ALU1, `HSOU_AF_SHR, 8'hd5, 0, 0);
		pk(0, 5, 32'hfffffff8);
		op(`HSOU_OP_ALU1, `HSOU_AF_SHR, 8'hd5, 0, 0);
		pk(0, 5, 32'h7ffffffc);
	endtask
	task t_branch;
		ld(1, 5);
		ld(2, 9);
		ld(7, 0);
		op(`HSOU_OP_BR2, 0, 8'h12, 32'h10, 0);
		bc <= `HSOU_BC_NE;
		pc <= 16'h100;
		w;
		chk({pl, pn}, {1'b1, 16'h110});
		op(`HSOU_OP_BR1, 0, 8'h72, 0, 0);
		bc <= `HSOU_BC_EQ;
		w;
		chk({pl, pn}, {1'b1, 16'h109});
		fx = 5'h04;
		op(`HSOU_OP_BR1, 0, 8'h72, 32'hfffe, 0);
		w;
		chk({pl, pn}, {1'b1, 16'h00fe});
		op(`HSOU_OP_BR1, 0, 8'h12, 0, 0);
		w;
		chk(pl, 0);
	endtask
	task t_memreg;
		op(`HSOU_OP_MRD, 0, 8'h42, 32'hff3, 32'h1234abcd);
		w;
		chk({mr, ma}, {1'b1, 16'h000c});
		pk(0, 4, 32'h1234abcd);
		fx = 5'h01;
		op(`HSOU_OP_MWR, 0, 8'h42, 32'h5, 0);
		w;
		chk({mw, mwo, ma}, {2'b10, 16'h000e});
		chk(wd, 32'h0000abcd);
		op(`HSOU_OP_RWR, 0, 8'h40, 32'h5, 0);
		w;
		chk({rw, ra, rwd}, {5'h15, 32'h1234abcd});
		op(`HSOU_OP_RRD, 0, 8'h60, 32'h5, 0);
		w;
		chk({rr, ra}, {1'b1, 4'h5});
		pk(0, 6, 32'h1234abcd);
	endtask
	task t_call_irq;
		ld(3, 32'h200);
		op(`HSOU_OP_CALL, 0, 8'h13, 0, 0);
		pc <= 16'h40;
		w;
		chk({pl, pn}, {1'b1, 16'h200});
		pk(0, 1, 32'h40);
		fx = 5'h08;
		op(`HSOU_OP_ALU2, `HSOU_AF_ADD, 8'h11, 0, 0);
		pc <= 16'h77;
		pk(0, 0, 32'h77);
		pk(0, 1, 32'h40);
	endtask
	// thread 2 fills a stack while thread 0 keeps its own
	task t_full;
		ld(2, 1);
		thr <= 2;
		ld(2, 2);
		ld(2, 3);
		ld(2, 4);
		ld(2, 5);
		w;
		chk({eu, es, et}, {1'b1, 8'h04, 3'h2});
		pk(0, 2, 4);
		op(`HSOU_OP_ALU1, `HSOU_AF_CPY, 8'ha2, 0, 0);
		w;
		chk({eu, eo}, 0);
		op(`HSOU_OP_ALU1, `HSOU_AF_CPY, 8'hb2, 0, 0);
		w;
		chk({eo, es}, {1'b1, 8'h08});
		pk(1, 3, 4);
		er(3);
		op(`HSOU_OP_MWR, 0, 8'h27, 0, 0);
		thr <= 0;
		w;
		chk(wd, 9);
	endtask
	task stop_test;
		$display("checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// a hang costs far more than the under a hundred cycles of the run
	initial
	begin
		#20000;
		err_count++;
		stop_test;
	end
	initial
	begin
		repeat (4) @(posedge clk);
		rst <= 0;
		t_modes;
		t_alu;
		t_branch;
		t_memreg;
		t_call_irq;
		t_full;
		stop_test;
	end
endmodule
`default_nettype wire
